// ==== hw/local_scratchpad.sv ====
// banked local scratchpad serving one 32-lane request window
`timescale 1ns/1ps
`default_nettype none
module local_scratchpad (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration
   input wire logic small_cfg,
   // only lane requests reach storage, no host port
   // request window: lane 2s+t is slot t of stream processor s
   input wire logic grp_valid,
   output logic grp_ready,
   input wire logic [scratchpad_pkg::LANES-1:0] grp_lane_en,
   input wire logic [scratchpad_pkg::LANES-1:0] grp_we,
   input wire logic [scratchpad_pkg::LANES-1:0][1:0] grp_size,
   input wire logic [scratchpad_pkg::LANES-1:0][scratchpad_pkg::ADDR_W-1:0]
      grp_addr,
   input wire logic [scratchpad_pkg::LANES-1:0][scratchpad_pkg::DATA_W-1:0]
      grp_wdata,
   // responses
   output logic [scratchpad_pkg::LANES-1:0] rsp_lane_r,
   output logic [scratchpad_pkg::LANES-1:0][scratchpad_pkg::DATA_W-1:0]
      rsp_data_r,
   output logic grp_done_r,
   output logic stall,
   // performance
   output logic [scratchpad_pkg::PCT_W-1:0] bank_stall_percentage
);
   localparam int L = scratchpad_pkg::LANES;
   localparam int B = scratchpad_pkg::BANKS;
   localparam int AW = scratchpad_pkg::ADDR_W;
   localparam int DW = scratchpad_pkg::DATA_W;
   localparam int IW = scratchpad_pkg::IDX_W;
   localparam int KW = scratchpad_pkg::KEY_W;

   // =====================================================
   // state
   scratchpad_pkg::sp_state_e state_r;
   scratchpad_pkg::sp_state_e state_nxt;
   logic [L-1:0] pend_r;
   logic [L-1:0] pend_nxt;
   logic [L-1:0] we_r;
   logic [L-1:0][1:0] size_r;
   logic [L-1:0][AW-1:0] addr_r;
   logic [L-1:0][DW-1:0] wdata_r;
   logic small_r;
   logic accept;
   logic busy;

   // a whole window is taken at once and closed before the next
   assign busy = (state_r == scratchpad_pkg::ST_BUSY);
   assign grp_ready = (state_r == scratchpad_pkg::ST_IDLE);
   assign accept = grp_valid && grp_ready;

   // =====================================================
   // lane decode
   logic [L-1:0][KW-1:0] key;
   logic [L-1:0][KW-1:0] phys;
   logic [L-1:0][IW-1:0] idx;
   logic [L-1:0][3:0] be;
   logic [L-1:0][DW-1:0] wd_al;

   always_comb begin
      for (int i = 0; i < L; i++) begin
         phys[i] = addr_r[i][scratchpad_pkg::IDX_LSB-1:scratchpad_pkg::BANK_LSB];
         // small mode: 16 logical banks, each two physical halves
         key[i] = small_r ?
            {1'b0, addr_r[i][scratchpad_pkg::SMALL_KEY_MSB:
                             scratchpad_pkg::BANK_LSB]} :
            phys[i];
         idx[i] = addr_r[i][AW-1:scratchpad_pkg::IDX_LSB];
         case (size_r[i])
            scratchpad_pkg::SIZE_BYTE: begin
               be[i] = 4'(scratchpad_pkg::BE_BYTE << addr_r[i][1:0]);
            end
            scratchpad_pkg::SIZE_HALF: begin
               be[i] = 4'(scratchpad_pkg::BE_HALF << {addr_r[i][1], 1'b0});
            end
            default: begin
               be[i] = scratchpad_pkg::BE_WORD;
            end
         endcase
         wd_al[i] = DW'(wdata_r[i] << {addr_r[i][1:0], 3'h0});
      end
   end

   // =====================================================
   // arbitration: lowest pending lane owns its bank this cycle
   logic [L-1:0] first;
   logic [L-1:0] served;

   always_comb begin
      for (int i = 0; i < L; i++) begin
         first[i] = pend_r[i];
         for (int j = 0; j < L; j++) begin
            if (j < i && pend_r[j] && key[j] == key[i]) begin
               first[i] = 1'b0;
            end
         end
      end
      for (int i = 0; i < L; i++) begin
         served[i] = pend_r[i];
         for (int j = 0; j < L; j++) begin
            // same address rides along with the owner
            if (j < i && first[j] && key[j] == key[i]
                && addr_r[j] != addr_r[i]) begin
               served[i] = 1'b0;
            end
         end
      end
   end

   // replay cycle whenever some lane had to wait
   assign stall = busy && (served != pend_r);
   assign pend_nxt = pend_r & ~served;

   // =====================================================
   // bank drive
   logic [B-1:0] bk_we;
   logic [B-1:0][3:0] bk_be;
   logic [B-1:0][IW-1:0] bk_idx;
   logic [B-1:0][DW-1:0] bk_wd;
   logic [B-1:0][DW-1:0] bk_rd;

   always_comb begin
      for (int b = 0; b < B; b++) begin
         bk_we[b] = 1'b0;
         bk_be[b] = 4'h0;
         bk_idx[b] = '0;
         bk_wd[b] = '0;
         // ascending scan: higher lanes overwrite lower ones
         for (int i = 0; i < L; i++) begin
            if (served[i] && phys[i] == KW'(b)) begin
               bk_idx[b] = idx[i];
               if (we_r[i]) begin
                  bk_we[b] = 1'b1;
                  bk_be[b] = bk_be[b] | be[i];
                  for (int k = 0; k < scratchpad_pkg::WORD_BYTES; k++) begin
                     if (be[i][k]) begin
                        bk_wd[b][8*k +: 8] = wd_al[i][8*k +: 8];
                     end
                  end
               end
            end
         end
      end
   end

   // 32 banks x 256 words x 4 bytes gives 32K per unit
   for (genvar g = 0; g < B; g++) begin : g_bank
      scratchpad_bank u_bank (
         .ref_clk(ref_clk),
         .wr_en(bk_we[g]),
         .byte_en(bk_be[g]),
         .idx(bk_idx[g]),
         .wr_data(bk_wd[g]),
         .rd_data(bk_rd[g])
      );
   end

   // =====================================================
   // read extraction: every read costs one full word slot
   logic [L-1:0][DW-1:0] rd_lane;

   always_comb begin
      for (int i = 0; i < L; i++) begin
         rd_lane[i] = bk_rd[phys[i]] >> {addr_r[i][1:0], 3'h0};
         case (size_r[i])
            scratchpad_pkg::SIZE_BYTE: begin
               rd_lane[i] = {24'h000000, rd_lane[i][7:0]};
            end
            scratchpad_pkg::SIZE_HALF: begin
               rd_lane[i] = {16'h0000, rd_lane[i][15:0]};
            end
            default: begin
               rd_lane[i] = rd_lane[i];
            end
         endcase
      end
   end

   // =====================================================
   // control
   always_comb begin
      case (state_r)
         scratchpad_pkg::ST_IDLE: begin
            state_nxt = accept ? scratchpad_pkg::ST_BUSY :
               scratchpad_pkg::ST_IDLE;
         end
         scratchpad_pkg::ST_BUSY: begin
            state_nxt = (pend_nxt == '0) ? scratchpad_pkg::ST_IDLE :
               scratchpad_pkg::ST_BUSY;
         end
         default: begin
            state_nxt = scratchpad_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= scratchpad_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // an empty window still takes one cycle to close
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_r <= scratchpad_pkg::MASK_RST;
      end else if (accept) begin
         pend_r <= grp_lane_en;
      end else if (busy) begin
         pend_r <= pend_nxt;
      end
   end

   // window capture; these only matter while lanes are pending
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         we_r <= scratchpad_pkg::MASK_RST;
         size_r <= '0;
         addr_r <= '0;
         wdata_r <= '0;
         small_r <= 1'b0;
      end else if (accept) begin
         we_r <= grp_we;
         size_r <= grp_size;
         addr_r <= grp_addr;
         wdata_r <= grp_wdata;
         small_r <= small_cfg;
      end
   end

   // =====================================================
   // responses: only the lanes served this cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rsp_lane_r <= scratchpad_pkg::MASK_RST;
         grp_done_r <= 1'b0;
      end else begin
         rsp_lane_r <= busy ? served : scratchpad_pkg::MASK_RST;
         grp_done_r <= busy && (pend_nxt == '0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rsp_data_r <= '0;
      end else begin
         for (int i = 0; i < L; i++) begin
            if (busy && served[i] && !we_r[i]) begin
               rsp_data_r[i] <= rd_lane[i];
            end
         end
      end
   end

   stall_meter u_meter (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .stall(stall),
      .bank_stall_percentage(bank_stall_percentage)
   );

   // =====================================================
   // checks
   logic bank_viol;
   logic bcast_viol;
   logic [5:0] busy_cnt_r;

   always_comb begin
      bank_viol = 1'b0;
      bcast_viol = 1'b0;
      for (int i = 0; i < L; i++) begin
         for (int j = 0; j < L; j++) begin
            if (i != j && served[i] && served[j] && key[i] == key[j]
                && addr_r[i] != addr_r[j]) begin
               bank_viol = 1'b1;
            end
            if (served[i] && pend_r[j] && !served[j]
                && addr_r[i] == addr_r[j]) begin
               bcast_viol = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || !busy) begin
         busy_cnt_r <= 6'h00;
      end else begin
         busy_cnt_r <= busy_cnt_r + 6'h01;
      end
   end

   a_busy_refuse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busy |-> !grp_ready)
      else $error("window accepted while busy");
   a_done_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
      grp_done_r |-> grp_ready && !$past(grp_ready))
      else $error("done without closing the window");
   a_serve_subset: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busy |=> (rsp_lane_r & ~$past(pend_r)) == '0)
      else $error("response on a lane not pending");
   a_serve_progress: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      busy && pend_r != '0 |-> served != '0)
      else $error("no lane served in a busy cycle");
   a_one_bank: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !bank_viol)
      else $error("two addresses on one bank in one cycle");
   a_broadcast_same: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !bcast_viol)
      else $error("same address not broadcast");
   a_stall_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stall |=> !grp_ready ##0 rsp_lane_r != '0)
      else $error("stall did not replay");
   a_latency_bound: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      busy |-> busy_cnt_r < 6'h20)
      else $error("window took more than 32 cycles");

   // =====================================================
   // window protocol: load, pulse widths, clean finish
   a_accept_load: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      accept |=> busy && pend_r == $past(grp_lane_en))
      else $error("accepted window not loaded as pending");
   a_done_pulse: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      grp_done_r |=> !grp_done_r)
      else $error("done pulse longer than one cycle");
   a_rsp_after_busy: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rsp_lane_r != '0 |-> $past(busy))
      else $error("response without a service cycle");
   a_clean_finish: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      busy && !stall |=> grp_done_r)
      else $error("conflict-free cycle did not close the window");
endmodule
`default_nettype wire

// ==== hw/scratchpad_pkg.sv ====
// constants, types and notes for the banked local scratchpad
// Functional notes
// - 32K storage per unit, shared by work-group
// - large mode: 32 banks, 4 bytes wide
// - large mode bank from address bits 6:2
// - small mode: 16 banks, bits 5:2
// - one request per bank each cycle
// - same-bank different addresses serialized, consecutive cycles
// - conflict stalls; replays enable only unserved lanes
// - latency equals load on busiest bank
// - identical addresses broadcast, never a conflict
// - conflicts checked over 32-request two-cycle window
// - two 4-byte requests per stream processor
// - byte and halfword reads take full slot
// - one operation launches two loads
// - stall percentage measure, zero without conflicts
// - data kept until overwritten, no eviction
// - no host path into the storage
// - whole wavefront group executes as one unit
package scratchpad_pkg;
   // =====================================================
   // geometry
   localparam int LANES = 32;
   localparam int SLOTS_PER_SP = 2;
   localparam int BANKS = 32;
   localparam int WORD_BYTES = 4;
   localparam int BANK_DEPTH = 256;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 32;
   localparam int IDX_W = 8;
   localparam int KEY_W = 5;
   localparam int BANK_LSB = 2;
   localparam int IDX_LSB = 7;
   localparam int SMALL_KEY_MSB = 5;
   // =====================================================
   // access sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [3:0] BE_BYTE = 4'h1;
   localparam logic [3:0] BE_HALF = 4'h3;
   localparam logic [3:0] BE_WORD = 4'hF;
   // =====================================================
   // performance window and reset values
   localparam int PCT_WINDOW = 100;
   localparam int PCT_W = 7;
   localparam logic [PCT_W-1:0] PCT_RST = 7'h00;
   localparam logic [LANES-1:0] MASK_RST = 32'h0000_0000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } sp_state_e;
endpackage

// ==== hw/scratchpad_bank.sv ====
// one four-byte-wide scratchpad bank with byte enables
`timescale 1ns/1ps
`default_nettype none
module scratchpad_bank (
   // clock
   input wire logic ref_clk,
   // access
   input wire logic wr_en,
   input wire logic [3:0] byte_en,
   input wire logic [scratchpad_pkg::IDX_W-1:0] idx,
   input wire logic [scratchpad_pkg::DATA_W-1:0] wr_data,
   output logic [scratchpad_pkg::DATA_W-1:0] rd_data
);
   // =====================================================
   // storage
   // no reset and no eviction: contents live until overwritten
   logic [scratchpad_pkg::DATA_W-1:0] mem [scratchpad_pkg::BANK_DEPTH];

   always_ff @(posedge ref_clk) begin
      for (int k = 0; k < scratchpad_pkg::WORD_BYTES; k++) begin
         if (wr_en && byte_en[k]) begin
            mem[idx][8*k +: 8] <= wr_data[8*k +: 8];
         end
      end
   end

   // read sees the old word when a write hits the same cycle
   assign rd_data = mem[idx];
endmodule
`default_nettype wire

// ==== hw/stall_meter.sv ====
// bank conflict stall percentage over a fixed window
`timescale 1ns/1ps
`default_nettype none
module stall_meter (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // event
   input wire logic stall,
   // measure
   output logic [scratchpad_pkg::PCT_W-1:0] bank_stall_percentage
);
   // =====================================================
   // window counters
   // window of 100 cycles makes the count a percentage, no divider
   logic [scratchpad_pkg::PCT_W-1:0] win_r;
   logic [scratchpad_pkg::PCT_W-1:0] cnt_r;
   logic win_end;
   logic [scratchpad_pkg::PCT_W-1:0] cnt_nxt;

   assign win_end = (win_r == 7'(scratchpad_pkg::PCT_WINDOW - 1));
   assign cnt_nxt = cnt_r + {6'h00, stall};

   always_ff @(posedge ref_clk) begin
      if (!rst_n || win_end) begin
         win_r <= scratchpad_pkg::PCT_RST;
      end else begin
         win_r <= win_r + 7'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || win_end) begin
         cnt_r <= scratchpad_pkg::PCT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bank_stall_percentage <= scratchpad_pkg::PCT_RST;
      end else if (win_end) begin
         bank_stall_percentage <= cnt_nxt;
      end
   end

   a_pct_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      win_end && cnt_nxt == 7'h00 |=> bank_stall_percentage == 7'h00)
      else $error("stall measure not zero without stalls");
endmodule
`default_nettype wire

// ==== verification/wave_lanes.sv ====
// lane-side model issuing one 32-lane request window at a time
`timescale 1ns/1ps
`default_nettype none
module wave_lanes (
   // clock
   input wire logic ref_clk,
   // window
   output logic grp_valid,
   input wire logic grp_ready,
   output logic [31:0] grp_lane_en,
   output logic [31:0] grp_we,
   output logic [31:0][1:0] grp_size,
   output logic [31:0][14:0] grp_addr,
   output logic [31:0][31:0] grp_wdata,
   // responses
   input wire logic [31:0] rsp_lane_r,
   input wire logic [31:0][31:0] rsp_data_r,
   input wire logic grp_done_r,
   input wire logic stall
);
   initial begin
      grp_valid = 1'b0;
      grp_lane_en = '0;
      grp_we = '0;
      grp_size = '0;
      grp_addr = '0;
      grp_wdata = '0;
   end
   // =====================================================
   // one window: offer, hold until taken, collect answers
   task automatic send(input logic [31:0] en, input logic [31:0] we,
      input logic [31:0][1:0] sz, input logic [31:0][14:0] ad,
      input logic [31:0][31:0] wd, input int gap, output int n,
      output int stalls, output logic [31:0] got,
      output logic [31:0][31:0] rd);
      repeat (gap + 1) @(negedge ref_clk);
      grp_valid = 1'b1;
      grp_lane_en = en;
      grp_we = we;
      grp_size = sz;
      grp_addr = ad;
      grp_wdata = wd;
      while (grp_ready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      @(negedge ref_clk);
      // released lines must not keep looking valid
      grp_valid = 1'b0;
      grp_lane_en = ~en;
      grp_we = ~we;
      grp_addr = ~ad;
      grp_wdata = ~wd;
      n = 0;
      stalls = 0;
      got = '0;
      rd = '0;
      // next window only after done: barrier duty
      do begin
         if (n > 0) @(negedge ref_clk);
         n++;
         if (stall === 1'b1) stalls++;
         for (int i = 0; i < 32; i++) begin
            if (rsp_lane_r[i] === 1'b1) begin
               got[i] = 1'b1;
               rd[i] = rsp_data_r[i];
            end
         end
      end while (grp_done_r !== 1'b1 && n < 40);
   endtask
endmodule
`default_nettype wire

// ==== verification/tb_local_scratchpad.sv ====
// self-checking bench for the banked local scratchpad
`timescale 1ns/1ps
`default_nettype none
module tb_local_scratchpad;
   logic ref_clk;
   logic rst_n;
   logic small_cfg;
   logic grp_valid;
   logic grp_ready;
   logic [31:0] grp_lane_en;
   logic [31:0] grp_we;
   logic [31:0][1:0] grp_size;
   logic [31:0][14:0] grp_addr;
   logic [31:0][31:0] grp_wdata;
   logic [31:0] rsp_lane_r;
   logic [31:0][31:0] rsp_data_r;
   logic grp_done_r;
   logic stall;
   logic [6:0] bank_stall_percentage;
   logic [31:0] en, we, got;
   logic [31:0][1:0] sz;
   logic [31:0][14:0] ad;
   logic [31:0][31:0] wd, rd;
   int n, st, error_cnt, total_checks;
   // =====================================================
   // clock, design and lane model
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;
   local_scratchpad i_local_scratchpad (
      .ref_clk(ref_clk), .rst_n(rst_n), .small_cfg(small_cfg),
      .grp_valid(grp_valid), .grp_ready(grp_ready),
      .grp_lane_en(grp_lane_en), .grp_we(grp_we), .grp_size(grp_size),
      .grp_addr(grp_addr), .grp_wdata(grp_wdata),
      .rsp_lane_r(rsp_lane_r), .rsp_data_r(rsp_data_r),
      .grp_done_r(grp_done_r), .stall(stall),
      .bank_stall_percentage(bank_stall_percentage));
   wave_lanes i_wave_lanes (
      .ref_clk(ref_clk), .grp_valid(grp_valid), .grp_ready(grp_ready),
      .grp_lane_en(grp_lane_en), .grp_we(grp_we), .grp_size(grp_size),
      .grp_addr(grp_addr), .grp_wdata(grp_wdata),
      .rsp_lane_r(rsp_lane_r), .rsp_data_r(rsp_data_r),
      .grp_done_r(grp_done_r), .stall(stall));
   // =====================================================
   // shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic fill(input logic w, input logic [1:0] s, input int step);
      for (int i = 0; i < 32; i++) begin
         en[i] = 1'b1;
         we[i] = w;
         sz[i] = s;
         ad[i] = 15'(step * i);
         wd[i] = 32'h5A00_0000 + 32'(i);
      end
   endtask
   task automatic go(input int gap);
      i_wave_lanes.send(en, we, sz, ad, wd, gap, n, st, got, rd);
   endtask
   task automatic check_rd(input int step);
      for (int i = 0; i < 32; i++) begin
         check(rd[i], 32'h5A00_0000 + 32'(step * i / 128));
      end
   endtask
   // =====================================================
   // scenarios
   task automatic t_spread();
      fill(1'b1, 2'h2, 4);
      go(0);
      check(n, 2);
      check(st, 0);
      check(got, 32'hFFFF_FFFF);
      fill(1'b0, 2'h2, 4);
      go(3);
      check(n, 2);
      for (int i = 0; i < 32; i++) begin
         check(rd[i], 32'h5A00_0000 + 32'(i));
      end
   endtask
   task automatic t_one_bank();
      int mx;
      mx = 0;
      fill(1'b1, 2'h2, 128);
      go(0);
      check(n, 33);
      check(st, 31);
      // the 31 stalls may straddle two meter windows
      repeat (210) begin
         @(negedge ref_clk);
         if (int'(bank_stall_percentage) > mx) mx = bank_stall_percentage;
      end
      check(32'(mx >= 16 && mx <= 31), 1);
      fill(1'b0, 2'h2, 128);
      go(1);
      check(n, 33);
      check(got, 32'hFFFF_FFFF);
      check_rd(128);
   endtask
   task automatic t_broadcast();
      fill(1'b0, 2'h2, 0);
      for (int i = 0; i < 32; i++) ad[i] = 15'h0280;
      go(0);
      check(n, 2);
      check(st, 0);
      for (int i = 0; i < 32; i++) check(rd[i], 32'h5A00_0005);
   endtask
   task automatic t_small();
      small_cfg = 1'b1;
      fill(1'b0, 2'h2, 4);
      go(0);
      check(n, 3);
      check(st, 1);
      small_cfg = 1'b0;
      for (int i = 0; i < 32; i++) check(rd[i], 32'h5A00_0000 + 32'(i));
   endtask
   task automatic t_narrow();
      fill(1'b1, 2'h2, 0);
      en = 32'h0000_0001;
      ad[0] = 15'h0400;
      wd[0] = 32'hC3A5_96F0;
      go(0);
      fill(1'b0, 2'h0, 0);
      en = 32'h0000_0003;
      ad[0] = 15'h0400;
      ad[1] = 15'h0400;
      sz[1] = 2'h1;
      go(0);
      check(rd[0], 32'h0000_00F0);
      check(rd[1], 32'h0000_96F0);
      check(n, 2);
      // narrow write must touch only its own byte lane
      fill(1'b1, 2'h0, 0);
      en = 32'h0000_0001;
      ad[0] = 15'h0401;
      wd[0] = 32'h0000_0011;
      go(0);
      fill(1'b0, 2'h2, 0);
      en = 32'h0000_0001;
      ad[0] = 15'h0400;
      go(0);
      check(rd[0], 32'hC3A5_11F0);
   endtask
   task automatic t_same_write();
      fill(1'b1, 2'h2, 0);
      en = 32'h0000_0221;
      for (int i = 0; i < 32; i++) ad[i] = 15'h0800;
      go(0);
      check(n, 2);
      check(got, 32'h0000_0221);
      fill(1'b0, 2'h2, 0);
      en = 32'h0000_0001;
      ad[0] = 15'h0800;
      go(0);
      check(rd[0], 32'h5A00_0009);
   endtask
   // =====================================================
   // verdict and run control
   task automatic close_out();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      close_out();
   end
   initial begin
      error_cnt = 0;
      total_checks = 0;
      rst_n = 1'b0;
      small_cfg = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      check(grp_ready, 1);
      repeat (210) @(negedge ref_clk);
      check(bank_stall_percentage, 0);
      t_spread();
      t_one_bank();
      t_broadcast();
      t_small();
      t_narrow();
      t_same_write();
      close_out();
   end
endmodule
`default_nettype wire
